/* File: fbid_params.svh */
// Constants of the 14-bit instruction decoder: field positions, widths, timing.
// Assumes inclusion by fbid_pkg, the decoder modules and the port timing checker only.
`ifndef FBID_PARAMS_SVH
`define FBID_PARAMS_SVH
`define FBID_IW           14
`define FBID_FA_MSB       6
`define FBID_DEST_BIT     7
`define FBID_BSEL_LSB     7
`define FBID_BSEL_MSB     9
`define FBID_BOP_LSB      10
`define FBID_BOP_MSB      11
`define FBID_BYOP_LSB     8
`define FBID_BYOP_MSB     11
`define FBID_CLS_LSB      12
`define FBID_CLS_MSB      13
`define FBID_LIT8_MSB     7
`define FBID_LIT11_MSB    10
`define FBID_PHASES       4
`define FBID_TIMER_ZERO_COUNT_ADDR    7'h01
`define FBID_PORTA_ADDR   7'h05
`define FBID_PORTB_ADDR   7'h06
`define FBID_PORTC_ADDR   7'h07
`define FBID_RST_WORD     14'h0000
`endif

/* File: fbid_pkg.sv */
// Types of the 14-bit instruction decoder.
// Assumes fbid_params.svh is on the include path.
`include "fbid_params.svh"
package fbid_pkg;
  typedef enum logic [1:0] {
    FBID_CLS_BYTE,
    FBID_CLS_BIT,
    FBID_CLS_CTRL,
    FBID_CLS_LIT
  } fbid_class_type;
  typedef enum logic [1:0] {
    FBID_BIT_CLR,
    FBID_BIT_SET,
    FBID_BIT_TSTC,
    FBID_BIT_TSTS
  } fbid_bitop_type;
  typedef logic [`FBID_IW-1:0] fbid_word_type;
endpackage : fbid_pkg

/* File: fbid_phase_gen.sv */
// Four-phase instruction cycle generator.
// Assumes one free-running oscillator clock and a synchronous reset.
`include "fbid_params.svh"
module fbid_phase_gen (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Phase outputs
  output logic [1:0]      o_phase,
  output logic            o_cycle_end
);
  logic [1:0] phase_q;
  // ****************************************
  // Phase counter
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign o_phase     = phase_q;
  assign o_cycle_end = (phase_q == 2'(`FBID_PHASES - 1));
endmodule : fbid_phase_gen

/* File: fbid_decoder.sv */
// Instruction decoder and sequencer for an 8-bit core with 14-bit words.
// Assumes program memory presents i_instr stable across each instruction cycle,
// and the file space returns read data combinationally to o_fr_addr.
//
// Functional notes
// - Each 14-bit word splits into opcode and operand fields by category.
// - Byte operations: destination zero writes W, one writes the file register.
// - File address operand is seven bits, 0x00 through 0x7F.
// - Bit selector picks one bit of the 8-bit register to set, clear, test.
// - Literal is 8 bits; call and jump targets are 11 bits.
// - Each instruction cycle is exactly four oscillator periods.
// - One cycle normally; taken skips and program counter changes take two.
// - File-register instructions always read; only those with a file destination then modify and store, bit tests never store.
// - Don't-care opcode bits never change the decode.
// - Modify of an I/O register reads pin levels, not the output latch.
// - Writing the timer-zero count clears an assigned prescaler.
// - Bit operations lead with 01, then op, selector, file address.
`include "fbid_params.svh"
module fbid_decoder #(
  parameter int PCW = 13
) (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  // Program memory
  input  wire fbid_pkg::fbid_word_type i_instr,
  output logic [PCW-1:0]              o_program_counter,
  // File register space
  output logic [`FBID_FA_MSB:0]       o_fr_addr,
  input  wire logic [7:0]             i_fr_rdata,
  input  wire logic [7:0]             i_pin_rdata,
  output logic                        o_fr_rd,
  output logic [7:0]                  o_fr_wdata,
  output logic                        o_fr_we,
  // Timer zero
  input  wire logic                   i_psa_to_timer,
  output logic                        o_prescaler_clr,
  // Core state
  output logic [7:0]                  o_w,
  output logic                        o_zero,
  output logic                        o_carry,
  output logic                        o_flush
);
  import fbid_pkg::*;
  logic [1:0]           phase;
  logic                 cyc_end;
  fbid_class_type       cls;
  logic [3:0]           byop;
  fbid_bitop_type       bop;
  logic [2:0]           bsel;
  logic                 dest;
  logic [6:0]           fa;
  logic [7:0]           lit8;
  logic [10:0]          lit11;
  logic [7:0]           rd_val;
  logic [7:0]           res;
  logic [8:0]           sum;
  logic                 to_file;
  logic                 to_w;
  logic                 skip;
  logic                 jump;
  logic                 zflag;
  logic                 wr_c;
  logic                 cval;
  logic [PCW-1:0]       pc_q;
  logic [PCW-1:0]       stk_q;
  logic [7:0]           w_q;
  logic                 z_q;
  logic                 c_q;
  logic                 flush_q;
  logic [7:0]           pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [6:0]           addr_q;
  logic                 rd_q_en;
  logic [7:0]           wdata_q;
  logic                 we_q;
  logic                 psc_q;
  function automatic logic is_io(input logic [6:0] a);
    return (a == `FBID_PORTA_ADDR) || (a == `FBID_PORTB_ADDR) || (a == `FBID_PORTC_ADDR);
  endfunction : is_io
  fbid_phase_gen u_phase (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .o_phase     (phase),
    .o_cycle_end (cyc_end)
  );
  // ****************************************
  // Field split
  // ****************************************
  assign cls   = fbid_class_type'(i_instr[`FBID_CLS_MSB:`FBID_CLS_LSB]);
  assign byop  = i_instr[`FBID_BYOP_MSB:`FBID_BYOP_LSB];
  assign bop   = fbid_bitop_type'(i_instr[`FBID_BOP_MSB:`FBID_BOP_LSB]);
  assign bsel  = i_instr[`FBID_BSEL_MSB:`FBID_BSEL_LSB];
  assign dest  = i_instr[`FBID_DEST_BIT];
  assign fa    = i_instr[`FBID_FA_MSB:0];
  assign lit8  = i_instr[`FBID_LIT8_MSB:0];
  assign lit11 = i_instr[`FBID_LIT11_MSB:0];
  always_ff @(posedge i_mclk) begin
    pin_s1_q <= i_pin_rdata;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
  end
  assign rd_val = is_io(fa) ? pin_q : i_fr_rdata;
  // ****************************************
  // Execute decode
  // ****************************************
  always_comb begin
    res     = rd_val;
    sum     = 9'h000;
    to_file = 1'b0;
    to_w    = 1'b0;
    skip    = 1'b0;
    jump    = 1'b0;
    zflag   = 1'b0;
    wr_c    = 1'b0;
    cval    = c_q;
    unique case (cls)
      FBID_CLS_BYTE: begin
        to_file = dest;
        to_w    = ~dest;
        zflag   = 1'b1;
        unique case (byop)
          4'h0: begin
            res = dest ? w_q : 8'h00;
            to_w = 1'b0;
            zflag = 1'b0;
          end
          4'h1: res = 8'h00;
          4'h2: begin
            sum = {1'b0, rd_val} + {1'b0, ~w_q} + 9'h001;
            res = sum[7:0];
            wr_c = 1'b1;
            cval = sum[8];
          end
          4'h3: res = rd_val - 8'h01;
          4'h4: res = rd_val | w_q;
          4'h5: res = rd_val & w_q;
          4'h6: res = rd_val ^ w_q;
          4'h7: begin
            sum = {1'b0, rd_val} + {1'b0, w_q};
            res = sum[7:0];
            wr_c = 1'b1;
            cval = sum[8];
          end
          4'h8: res = rd_val;
          4'h9: res = ~rd_val;
          4'hA: res = rd_val + 8'h01;
          4'hB: begin
            res = rd_val - 8'h01;
            skip = (res == 8'h00);
            zflag = 1'b0;
          end
          4'hC: begin
            res = {c_q, rd_val[7:1]};
            wr_c = 1'b1;
            cval = rd_val[0];
            zflag = 1'b0;
          end
          4'hD: begin
            res = {rd_val[6:0], c_q};
            wr_c = 1'b1;
            cval = rd_val[7];
            zflag = 1'b0;
          end
          4'hE: begin
            res = {rd_val[3:0], rd_val[7:4]};
            zflag = 1'b0;
          end
          4'hF: begin
            res = rd_val + 8'h01;
            skip = (res == 8'h00);
            zflag = 1'b0;
          end
        endcase
      end
      FBID_CLS_BIT: begin
        unique case (bop)
          FBID_BIT_CLR: begin
            res = rd_val & ~(8'h01 << bsel);
            to_file = 1'b1;
          end
          FBID_BIT_SET: begin
            res = rd_val | (8'h01 << bsel);
            to_file = 1'b1;
          end
          FBID_BIT_TSTC: skip = ~rd_val[bsel];
          FBID_BIT_TSTS: skip = rd_val[bsel];
        endcase
      end
      FBID_CLS_CTRL: jump = 1'b1;
      FBID_CLS_LIT: begin
        to_w = 1'b1;
        zflag = 1'b1;
        casez (i_instr[11:8])
          4'b00??: begin
            res = lit8;
            zflag = 1'b0;
          end
          4'b01??: begin
            res = lit8;
            zflag = 1'b0;
            jump = 1'b1;
          end
          4'b1000: res = lit8 | w_q;
          4'b1001: res = lit8 & w_q;
          4'b1010: res = lit8 ^ w_q;
          4'b110?: begin
            sum = {1'b0, lit8} + {1'b0, ~w_q} + 9'h001;
            res = sum[7:0];
            wr_c = 1'b1;
            cval = sum[8];
          end
          4'b111?: begin
            sum = {1'b0, lit8} + {1'b0, w_q};
            res = sum[7:0];
            wr_c = 1'b1;
            cval = sum[8];
          end
          default: begin
            res = w_q;
            to_w = 1'b0;
            zflag = 1'b0;
          end
        endcase
      end
    endcase
    if (cls == FBID_CLS_BYTE && byop == 4'h0 && !dest && i_instr[3:1] == 3'b100) begin
      jump = 1'b1;
    end
  end
  // ****************************************
  // Read-modify-write to file space
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_q  <= 7'h00;
      rd_q_en <= 1'b0;
      wdata_q <= 8'h00;
      we_q    <= 1'b0;
      psc_q   <= 1'b0;
    end else begin
      addr_q  <= fa;
      rd_q_en <= (phase == 2'h0) && (cls != FBID_CLS_CTRL) && (cls != FBID_CLS_LIT);
      wdata_q <= res;
      we_q    <= (phase == 2'h2) && to_file && !flush_q;
      psc_q   <= (phase == 2'h2) && to_file && !flush_q && (fa == `FBID_TIMER_ZERO_COUNT_ADDR)
                 && i_psa_to_timer;
    end
  end
  // ****************************************
  // Working register, flags, sequencing
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      w_q     <= 8'h00;
      z_q     <= 1'b0;
      c_q     <= 1'b0;
      pc_q    <= '0;
      stk_q   <= '0;
      flush_q <= 1'b0;
    end else if (cyc_end) begin
      if (flush_q) begin
        flush_q <= 1'b0;
        pc_q    <= pc_q + 1'b1;
      end else begin
        if (to_w) begin
          w_q <= res;
        end
        if (zflag) begin
          z_q <= (res == 8'h00);
        end
        if (wr_c) begin
          c_q <= cval;
        end
        flush_q <= skip || jump;
        if (cls == FBID_CLS_CTRL) begin
          if (!i_instr[11]) begin
            stk_q <= pc_q + 1'b1;
          end
          pc_q <= PCW'(lit11) - 1'b1;
        end else if (jump) begin
          pc_q <= stk_q - 1'b1;
        end else begin
          pc_q <= pc_q + 1'b1;
        end
      end
    end
  end
  assign o_program_counter = pc_q;
  assign o_fr_addr         = addr_q;
  assign o_fr_rd           = rd_q_en;
  assign o_fr_wdata        = wdata_q;
  assign o_fr_we           = we_q;
  assign o_prescaler_clr   = psc_q;
  assign o_w               = w_q;
  assign o_zero            = z_q;
  assign o_carry           = c_q;
  assign o_flush           = flush_q;
endmodule : fbid_decoder

/* File: fbid_chk_sva.sv */
// Port timing checker of the 14-bit instruction decoder.
// Assumes binding to fbid_decoder, one clock and a synchronous reset.
`include "fbid_params.svh"
module fbid_chk #(
  parameter int PCW = 13
) (
  // Watched ports
  input wire logic                    i_mclk,
  input wire logic                    i_rst,
  input wire fbid_pkg::fbid_word_type i_instr,
  input wire logic [PCW-1:0]          o_program_counter,
  input wire logic [6:0]              o_fr_addr,
  input wire logic                    o_fr_rd,
  input wire logic                    o_fr_we,
  input wire logic                    i_psa_to_timer,
  input wire logic                    o_prescaler_clr,
  input wire logic [7:0]              o_w,
  input wire logic                    o_zero,
  input wire logic                    o_carry,
  input wire logic                    o_flush
);
  import fbid_pkg::*;
  wire logic [6:0] instr_fa = i_instr[6:0];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_we_pulse: assert property (o_fr_we |=> !o_fr_we [*3])
    else $error("file write not once per cycle");
  chk_rd_pulse: assert property (o_fr_rd |=> !o_fr_rd [*3])
    else $error("file read not once per cycle");
  chk_read_first: assert property (o_fr_we |-> $past(o_fr_rd, 2))
    else $error("file write without earlier read");
  chk_addr_field: assert property (o_fr_rd |-> o_fr_addr == $past(instr_fa))
    else $error("file address not taken from word");
  chk_flush_quiet: assert property (o_flush |=>
    !o_fr_we && $stable(o_w) && $stable(o_zero) && $stable(o_carry))
    else $error("flushed cycle changed state");
  chk_flush_len: assert property ($rose(o_flush) |-> o_flush [*4] ##1 !o_flush)
    else $error("no-op cycle length wrong");
  chk_pc_hold: assert property ($changed(o_program_counter) |=>
    $stable(o_program_counter) [*3])
    else $error("fetch address changed mid cycle");
  chk_tmr_clear: assert property (o_prescaler_clr ==
    (o_fr_we && o_fr_addr == `FBID_TIMER_ZERO_COUNT_ADDR && $past(i_psa_to_timer)))
    else $error("prescaler clear wrong");
endmodule : fbid_chk

bind fbid_decoder fbid_chk #(.PCW(PCW)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_instr(i_instr),
  .o_program_counter(o_program_counter), .o_fr_addr(o_fr_addr), .o_fr_rd(o_fr_rd),
  .o_fr_we(o_fr_we), .i_psa_to_timer(i_psa_to_timer), .o_prescaler_clr(o_prescaler_clr),
  .o_w(o_w), .o_zero(o_zero), .o_carry(o_carry), .o_flush(o_flush));

/* File: fbid_mem_model.sv */
// Program memory and file register space beside the decoder.
// Assumes the bench loads program words and file contents directly.
module fbid_mem_model (
  // Program memory
  input  wire logic [12:0]        i_program_counter,
  output fbid_pkg::fbid_word_type o_instr,
  // File register space
  input  wire logic               i_mclk,
  input  wire logic [6:0]         i_fr_addr,
  input  wire logic [7:0]         i_fr_wdata,
  input  wire logic               i_fr_we,
  output logic [7:0]              o_fr_rdata,
  output logic [7:0]              o_pin_rdata
);
  import fbid_pkg::*;
  fbid_word_type rom [0:2047];
  logic [7:0]    regs [0:127];
  logic [7:0]    pins;
  initial begin
    foreach (rom[i]) rom[i] = 14'h0000;
    foreach (regs[i]) regs[i] = 8'h00;
    pins = 8'h00;
  end
  assign o_instr = rom[i_program_counter[10:0]];
  assign o_fr_rdata = regs[i_fr_addr];
  assign o_pin_rdata = pins;
  always @(posedge i_mclk) begin
    if (i_fr_we) regs[i_fr_addr] <= i_fr_wdata;
  end
endmodule : fbid_mem_model

/* File: tb_top.sv */
// Bench of the 14-bit instruction decoder: runs one short program.
// Assumes decoder, package, checker and memory model compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fbid_pkg::*;
  // ********
  // Signals
  // ********
  logic          i_mclk = 1'b0;
  logic          i_rst = 1'b1;
  logic          psa = 1'b1;
  fbid_word_type instr;
  logic [12:0]   pc;
  logic [6:0]    fa;
  logic [7:0]    rdat, pdat, wdat, w;
  logic          rd, we, pclr, zero, carry, flush;
  int            failures = 0;
  int            check_count = 0;
  int            pclr_count = 0;
  fbid_word_type prog [0:10] = '{14'h333C, 14'h00FF, 14'h0A7F, 14'h17A0, 14'h1FA0,
    14'h30FF, 14'h1BA0, 14'h0886, 14'h0181, 14'h0181, 14'h2FF0};
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (pclr === 1'b1) pclr_count <= pclr_count + 1;
  end
  fbid_decoder #(.PCW(13)) DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_instr(instr),
    .o_program_counter(pc), .o_fr_addr(fa), .i_fr_rdata(rdat), .i_pin_rdata(pdat),
    .o_fr_rd(rd), .o_fr_wdata(wdat), .o_fr_we(we), .i_psa_to_timer(psa),
    .o_prescaler_clr(pclr), .o_w(w), .o_zero(zero), .o_carry(carry), .o_flush(flush));
  fbid_mem_model mdl (.i_program_counter(pc), .o_instr(instr), .i_mclk(i_mclk),
    .i_fr_addr(fa), .i_fr_wdata(wdat), .i_fr_we(we), .o_fr_rdata(rdat), .o_pin_rdata(pdat));
  // ********
  // Tasks
  // ********
  task automatic step(input int n);
    repeat (4 * n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask : step
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic t_literal();
    step(1);
    check("w", 16'(w), 16'h003C);
  endtask : t_literal
  task automatic t_dest();
    step(1);
    check("fr_7f", 16'(mdl.regs[127]), 16'h003C);
    step(1);
    check("w", 16'(w), 16'h003D);
    check("fr_7f", 16'(mdl.regs[127]), 16'h003C);
  endtask : t_dest
  task automatic t_bits();
    step(1);
    check("fr_20", 16'(mdl.regs[32]), 16'h0081);
    step(1);
    check("flush", 16'(flush), 16'h0001);
    step(1);
    check("w", 16'(w), 16'h003D);
    check("pc", 16'(pc), 16'h0006);
    step(1);
    check("flush", 16'(flush), 16'h0000);
    check("pc", 16'(pc), 16'h0007);
  endtask : t_bits
  task automatic t_pins();
    step(1);
    check("fr_06", 16'(mdl.regs[6]), 16'h005A);
  endtask : t_pins
  task automatic t_timer();
    int c;
    c = pclr_count;
    step(1);
    check("fr_01", 16'(mdl.regs[1]), 16'h0000);
    check("zero", 16'(zero), 16'h0001);
    check("pclr", 16'(pclr_count - c), 16'h0001);
    psa = 1'b0;
    step(1);
    check("pclr", 16'(pclr_count - c), 16'h0001);
  endtask : t_timer
  task automatic t_goto();
    step(1);
    check("flush", 16'(flush), 16'h0001);
    step(1);
    check("pc", 16'(pc), 16'h07F0);
    step(1);
    check("w", 16'(w), 16'h0055);
    step(1);
    check("w", 16'(w), 16'h0015);
    check("carry", 16'(carry), 16'h0001);
    check("zero", 16'(zero), 16'h0000);
  endtask : t_goto
  task automatic t_call();
    step(1);
    check("flush", 16'(flush), 16'h0001);
    step(1);
    check("pc", 16'(pc), 16'h0010);
    step(1);
    check("w", 16'(w), 16'h007E);
    check("flush", 16'(flush), 16'h0001);
    step(1);
    check("pc", 16'(pc), 16'h07F3);
    check("flush", 16'(flush), 16'h0000);
  endtask : t_call
  // ********
  // Sequence
  // ********
  initial begin
    @(negedge i_mclk);
    foreach (prog[i]) mdl.rom[i] = prog[i];
    mdl.rom[2032] = 14'h3055;
    mdl.rom[2033] = 14'h3EC0;
    mdl.rom[2034] = 14'h2010;
    mdl.rom[16] = 14'h347E;
    mdl.regs[32] = 8'h01;
    mdl.regs[6] = 8'hFF;
    mdl.regs[1] = 8'h77;
    mdl.pins = 8'h5A;
    @(negedge i_mclk);
    i_rst = 1'b0;
    t_literal();
    t_dest();
    t_bits();
    t_pins();
    t_timer();
    t_goto();
    t_call();
    finish_test();
  end
endmodule : tb_top
